// ==== hdl/ovrd_map.vh ====
`ifndef OVRD_MAP_VH
`define OVRD_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OVRD_ADDR_THRESHOLD_ZERO 10'h211
`define OVRD_ADDR_THRESHOLD_ONE 10'h212
`define OVRD_ADDR_CONFIG 10'h213
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define OVRD_RST_THRESHOLD_ZERO 8'hf2
`define OVRD_RST_THRESHOLD_ONE 8'hab
`define OVRD_RST_CONFIG 8'h07
`define OVRD_CFG_ENABLE_BIT 3
`define OVRD_CFG_EXP_MSB 2
`define OVRD_CFG_EXP_LSB 0
`define OVRD_CFG_USED_MASK 8'h0f
`define OVRD_EXT_BASE_SHIFT 3
`define OVRD_FULL_SCALE_SHIFT 9
`endif

// ==== hdl/ovrd_over_range_detector.v ====
// Summary of operation
// - flag zero set when sample magnitude reaches threshold zero, reset 0xf2.
// - flag one set when sample magnitude reaches threshold one, reset 0xab.
// - thresholds compare against magnitude scaled so full scale equals 256.
// - status pins driven only when enable bit 3 set; otherwise all low.
// - enable gates only the pins; link flags always follow detection.
// - each pin assertion lasts at least 8*2^exponent clock cycles while enable bit 3 stays set.
`timescale 1ns/1ps
`default_nettype none
`include "ovrd_map.vh"

module ovrd_over_range_detector #(
    parameter SAMPLE_WIDTH = 8,
    parameter ADDR_WIDTH = 10,
    // enough for the longest stretch, 8 * 2^7 cycles
    parameter CNT_WIDTH = 11
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [ADDR_WIDTH-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // samples, signed two's complement, one per clock per channel
    input wire signed [SAMPLE_WIDTH-1:0] chan_a_sample,
    input wire signed [SAMPLE_WIDTH-1:0] chan_b_sample,
    // status pins
    output reg chan_a_flag_zero_pin,
    output reg chan_a_flag_one_pin,
    output reg chan_b_flag_zero_pin,
    output reg chan_b_flag_one_pin,
    // flags for serial link framing, {b1,b0,a1,a0}
    output reg [3:0] link_flags
);

// ----------------------------------------
// helpers
// ----------------------------------------
// magnitude on a 0..256 scale; most negative code maps to 256,
// above any 8-bit threshold, so it always reaches both levels
function [8:0] mag256;
    input [SAMPLE_WIDTH-1:0] s;
    reg [SAMPLE_WIDTH:0] a;
    reg [SAMPLE_WIDTH+`OVRD_FULL_SCALE_SHIFT:0] w;
    begin
        a = {1'b0, s};
        if (s[SAMPLE_WIDTH-1]) begin
            a = {1'b0, ~s} + {{SAMPLE_WIDTH{1'b0}}, 1'b1};
        end
        // widen first; scaling in nine bits would shift the value out
        w = {{`OVRD_FULL_SCALE_SHIFT{1'b0}}, a} << `OVRD_FULL_SCALE_SHIFT;
        w = w >> SAMPLE_WIDTH;
        mag256 = w[8:0];
    end
endfunction

function [CNT_WIDTH-1:0] ext_len;
    input [2:0] e;
    begin
        ext_len = {{(CNT_WIDTH-1){1'b0}}, 1'b1} << (e + `OVRD_EXT_BASE_SHIFT);
    end
endfunction

function reaches;
    input [8:0] mag;
    input [7:0] level;
    begin
        reaches = mag >= {1'b0, level};
    end
endfunction

// reload on a hit, otherwise count down to zero and rest there
function [CNT_WIDTH-1:0] next_hold;
    input hit_now;
    input [CNT_WIDTH-1:0] cur;
    input [CNT_WIDTH-1:0] reload;
    begin
        if (hit_now) begin
            next_hold = reload;
        end else if (cur != {CNT_WIDTH{1'b0}}) begin
            next_hold = cur - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
        end else begin
            next_hold = {CNT_WIDTH{1'b0}};
        end
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] threshold_zero_q;
reg [7:0] threshold_one_q;
reg [7:0] detector_config_q;
reg [7:0] reg_rdata_d;
wire status_pin_enable = detector_config_q[`OVRD_CFG_ENABLE_BIT];
wire [2:0] pulse_extension_exponent =
    detector_config_q[`OVRD_CFG_EXP_MSB:`OVRD_CFG_EXP_LSB];
wire wr_threshold_zero = reg_wr && (reg_addr == `OVRD_ADDR_THRESHOLD_ZERO);
wire wr_threshold_one = reg_wr && (reg_addr == `OVRD_ADDR_THRESHOLD_ONE);
wire wr_config = reg_wr && (reg_addr == `OVRD_ADDR_CONFIG);

// writes to unmapped addresses fall through and are ignored
always @(posedge clk) begin
    if (srst) begin
        threshold_zero_q <= `OVRD_RST_THRESHOLD_ZERO;
        threshold_one_q <= `OVRD_RST_THRESHOLD_ONE;
        detector_config_q <= `OVRD_RST_CONFIG;
    end else begin
        if (wr_threshold_zero) begin
            threshold_zero_q <= reg_wdata;
        end
        if (wr_threshold_one) begin
            threshold_one_q <= reg_wdata;
        end
        // reserved bits are dropped here so they always read back as zero
        if (wr_config) begin
            detector_config_q <= reg_wdata & `OVRD_CFG_USED_MASK;
        end
    end
end

// read mux; unmapped addresses read as zero
always @* begin
    case (reg_addr)
        `OVRD_ADDR_THRESHOLD_ZERO: reg_rdata_d = threshold_zero_q;
        `OVRD_ADDR_THRESHOLD_ONE: reg_rdata_d = threshold_one_q;
        `OVRD_ADDR_CONFIG: reg_rdata_d = detector_config_q;
        default: reg_rdata_d = 8'h00;
    endcase
end

// read data holds until the next read strobe
always @(posedge clk) begin
    if (srst) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= reg_rdata_d;
    end
end

// ----------------------------------------
// detection
// ----------------------------------------
wire [8:0] mag_a = mag256(chan_a_sample);
wire [8:0] mag_b = mag256(chan_b_sample);
// each channel sees only its own magnitude
// a threshold of zero is reached by every sample, so it always hits
wire hit_a_zero = reaches(mag_a, threshold_zero_q);
wire hit_a_one = reaches(mag_a, threshold_one_q);
wire hit_b_zero = reaches(mag_b, threshold_zero_q);
wire hit_b_one = reaches(mag_b, threshold_one_q);
wire [3:0] hit = {hit_b_one, hit_b_zero, hit_a_one, hit_a_zero};

// ----------------------------------------
// link flags
// ----------------------------------------
// not gated by the pin enable, so framed flags keep flowing
always @(posedge clk) begin
    if (srst) begin
        link_flags <= 4'h0;
    end else begin
        link_flags <= hit;
    end
end

// ----------------------------------------
// pulse extension
// ----------------------------------------
// counter reloads on every hit, so the pin stays high for the full
// period after the last hit; a new hit retriggers rather than stacking
// the hit cycle counts as the first cycle of the stretch
// an exponent change mid-hold only takes effect on the next hit
wire [CNT_WIDTH-1:0] reload_len =
    ext_len(pulse_extension_exponent) - {{(CNT_WIDTH-1){1'b0}}, 1'b1};
reg [CNT_WIDTH-1:0] hold_q [0:3];
reg [3:0] ext_q;
integer i;
always @(posedge clk) begin
    if (srst) begin
        for (i = 0; i < 4; i = i + 1) begin
            hold_q[i] <= {CNT_WIDTH{1'b0}};
        end
        ext_q <= 4'h0;
    end else begin
        for (i = 0; i < 4; i = i + 1) begin
            hold_q[i] <= next_hold(hit[i], hold_q[i], reload_len);
            ext_q[i] <= hit[i] | (hold_q[i] != {CNT_WIDTH{1'b0}});
        end
    end
end

// ----------------------------------------
// pin gating
// ----------------------------------------
// gating sits after the stretch: clearing the enable drops the pins at
// once, while re-enabling shows any hold that is still running
reg [3:0] pins_d;
always @* begin
    pins_d = 4'h0;
    if (status_pin_enable) begin
        pins_d = ext_q;
    end
end

always @(posedge clk) begin
    if (srst) begin
        chan_a_flag_zero_pin <= 1'b0;
        chan_a_flag_one_pin <= 1'b0;
        chan_b_flag_zero_pin <= 1'b0;
        chan_b_flag_one_pin <= 1'b0;
    end else begin
        chan_a_flag_zero_pin <= pins_d[0];
        chan_a_flag_one_pin <= pins_d[1];
        chan_b_flag_zero_pin <= pins_d[2];
        chan_b_flag_one_pin <= pins_d[3];
    end
end

endmodule
`default_nettype wire

// ==== testbench/ovrd_over_range_detector_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ovrd_chk (
    input wire logic clk, srst, reg_wr, reg_rd,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    input wire logic signed [7:0] chan_a_sample, chan_b_sample,
    input wire logic chan_a_flag_zero_pin, chan_a_flag_one_pin,
    input wire logic chan_b_flag_zero_pin, chan_b_flag_one_pin,
    input wire logic [3:0] link_flags
);
    logic [7:0] t0_q, t1_q;
    logic [2:0] en_q;
    logic [3:0] hit_q;
    // most negative sample scales to 256, so nine bits
    function automatic [8:0] mg(input [7:0] s);
        mg = s[7] ? (9'h000 - {1'b1, s}) << 1 : {s, 1'b0};
    endfunction
    always @(posedge clk) begin
        if (srst) begin
            {t0_q, t1_q, en_q, hit_q} <= {8'hf2, 8'hab, 3'h0, 4'h0};
        end else begin
            if (reg_wr && reg_addr == 10'h211) t0_q <= reg_wdata;
            if (reg_wr && reg_addr == 10'h212) t1_q <= reg_wdata;
            en_q <= {en_q[1:0], (reg_wr && reg_addr == 10'h213) ? reg_wdata[3] : en_q[0]};
            hit_q <= {mg(chan_b_sample) >= t1_q, mg(chan_b_sample) >= t0_q,
                mg(chan_a_sample) >= t1_q, mg(chan_a_sample) >= t0_q};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence held_a0;
        (chan_a_flag_zero_pin || !en_q[1]) [*8];
    endsequence
    chk_flag_zero: assert property (link_flags[0] == hit_q[0]) else $error("flag zero");
    chk_flag_one: assert property (link_flags[1] == hit_q[1]) else $error("flag one");
    chk_chan_b: assert property (link_flags[3:2] == hit_q[3:2]) else $error("chan b");
    chk_pins_gated: assert property (en_q == 3'h0 |-> !(chan_a_flag_zero_pin || chan_a_flag_one_pin
        || chan_b_flag_zero_pin || chan_b_flag_one_pin)) else $error("pin while off");
    chk_pin_hold: assert property ($rose(chan_a_flag_zero_pin) |-> held_a0) else $error("short");
    chk_hold_b: assert property ($rose(chan_b_flag_one_pin) |-> (chan_b_flag_one_pin || !en_q[1]) [*8])
        else $error("short b");
    chk_reset_low: assert property ($fell(srst) |-> !chan_a_flag_one_pin) else $error("reset pin");
endmodule
`default_nettype wire

// ==== testbench/ovrd_pin_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ovrd_pin_monitor (
    input wire logic clk,
    input wire logic pin,
    output logic [7:0] last_width
);
    logic [7:0] cnt_q = 8'h00;
    initial last_width = 8'h00;
    // width latched when the pin drops; long holds would wrap
    always @(posedge clk) begin
        cnt_q <= pin ? cnt_q + 8'h01 : 8'h00;
        if (!pin && cnt_q != 8'h00) last_width <= cnt_q;
    end
endmodule
`default_nettype wire

// ==== testbench/ovrd_over_range_detector_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ovrd_over_range_detector_tb;
    logic clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00, chan_a_sample = 8'h00, chan_b_sample = 8'h00;
    wire [7:0] reg_rdata, width;
    wire [3:0] link_flags;
    wire a0, a1, b0, b1;
    int fail_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    ovrd_over_range_detector i_ovrd_over_range_detector (.clk(clk), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample), .chan_a_flag_zero_pin(a0),
        .chan_a_flag_one_pin(a1), .chan_b_flag_zero_pin(b0), .chan_b_flag_one_pin(b1),
        .link_flags(link_flags));
    ovrd_pin_monitor i_ovrd_pin_monitor (.clk(clk), .pin(a0), .last_width(width));
    task chk(input [7:0] s, e); begin
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t seen %h expected %h", $time, s, e);
        end
    end endtask
    task wr(input [9:0] a, input [7:0] d); begin
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1}; @(negedge clk); reg_wr = 0; @(negedge clk);
    end endtask
    task rd(input [9:0] a, input [7:0] e); begin
        {reg_addr, reg_rd} = {a, 1'b1}; @(negedge clk); reg_rd = 0; @(negedge clk); chk(reg_rdata, e);
    end endtask
    task smp(input [7:0] a, b, e); begin
        {chan_a_sample, chan_b_sample} = {a, b}; @(negedge clk); chk({4'h0, link_flags}, e);
        {chan_a_sample, chan_b_sample} = 0; @(negedge clk);
    end endtask
    task t_regs; begin
        rd(10'h211, 8'hf2); rd(10'h212, 8'hab); rd(10'h213, 8'h07); rd(10'h210, 8'h00);
        wr(10'h214, 8'h55); wr(10'h213, 8'hf0); rd(10'h213, 8'h00); rd(10'h211, 8'hf2);
    end endtask
    task t_gate; begin
        smp(8'h7f, 8'h80, 8'h0f);
        repeat (12) begin @(negedge clk); chk({4'h0, a0, a1, b0, b1}, 8'h00); end
    end endtask
    task t_hold; begin
        wr(10'h213, 8'h08); smp(8'h7f, 8'h00, 8'h03);
        chk({4'h0, a0, a1, b0, b1}, 8'h0c);
        repeat (20) @(negedge clk); chk(width, 8'd8);
        wr(10'h213, 8'h09); smp(8'h81, 8'h00, 8'h03);
        repeat (30) @(negedge clk); chk(width, 8'd16);
    end endtask
    task t_levels; begin
        smp(8'haa, 8'h00, 8'h02); smp(8'h55, 8'h00, 8'h00); smp(8'h00, 8'h80, 8'h0c);
        wr(10'h211, 8'h10); smp(8'h08, 8'h00, 8'h01); smp(8'h07, 8'h00, 8'h00);
        rd(10'h211, 8'h10);
    end endtask
    task results; begin
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end endtask
    initial begin #20000; fail_count++; results; end
    initial begin repeat (5) @(negedge clk); srst = 0; t_regs; t_gate; t_hold; t_levels; results; end
endmodule
bind ovrd_over_range_detector ovrd_chk i_ovrd_chk (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .chan_a_sample(chan_a_sample), .chan_b_sample(chan_b_sample),
    .chan_a_flag_zero_pin(chan_a_flag_zero_pin), .chan_a_flag_one_pin(chan_a_flag_one_pin),
    .chan_b_flag_zero_pin(chan_b_flag_zero_pin), .chan_b_flag_one_pin(chan_b_flag_one_pin),
    .link_flags(link_flags));
`default_nettype wire
